// ---- hw/glyph_pkg.sv ----
// glyph_pkg: shared constants for glyph and icon pattern lookup.
// assumes a single display clock domain; no register bus, all controls are ports.
// Operation
// - text code bits 0..2 become user glyph RAM address bits 3..5.
// - address bits 0..2 pick the row; row 8 is ORed with cursor.
// - rightmost dot in bit 0; 5-wide uses bits 0..4, 6-wide bits 0..5.
// - codes with bits 7..4 zero select user RAM; bit 3 ignored.
// - user RAM bit 1 lights the dot, 0 leaves it dark.
// - blink enable and row bit 7 blink the set low six bits.
// - blink enable and row bit 6 blink bit 4 (5-wide) or bit 5 (6-wide).
// - icon RAM bits 7 and 6 blink just like the user RAM case.
// - 5-wide: entry n gives segments 5n+1..5n+5, bit 4 leftmost.
// - 6-wide: entry n gives segments 6n+1..6n+6, bit 5 leftmost.
// - 5-wide ignores icon entry bit 5.
// - icon data driven only on common row first and last (same signal).
// - segments 1..60 shown locally; 61 onward go to extension driver.
// - segment sequence wraps after 80 (5-wide) or 96 (6-wide).
// - icon bit 1 drives segment selected, 0 non-selected.
// - fixed glyph ROM holds 240 patterns of 5x8 by code and row.
// - ROM content outside the pattern area has no display effect.
// - unprogrammed ROM patterns show all dots lit; zero ones are blank.
// - blink enable resets to 0.
// - font width select resets to 0, five dots.
// - cursor style select resets to 0, normal eighth-row cursor.
package glyph_pkg;
    localparam int          CODE_W         = 8;
    localparam int          ROW_W          = 3;
    localparam int          DOT_W          = 6;
    localparam int          UG_ADDR_W      = 6;
    localparam int          ICON_ENTRIES   = 16;
    localparam int          ICON_ADDR_W    = 4;
    localparam int          SEG_TOTAL      = 96;
    localparam int          SEG_LOCAL      = 60;
    localparam int          SEG_EXT        = SEG_TOTAL - SEG_LOCAL;
    localparam int          SEG_WRAP_5     = 80;
    localparam int          SEG_WRAP_6     = 96;
    localparam int          ROM_PATTERNS   = 240;
    localparam int          BLINK_BIT_ALL  = 7;
    localparam int          BLINK_BIT_EDGE = 6;
    localparam logic [2:0]  CURSOR_ROW     = 3'h7;
    localparam logic [5:0]  ROM_BLANK_ROW  = 6'h1f;
    localparam logic [3:0]  USER_CODE_HI   = 4'h0;
    localparam logic        RST_BLINK_EN   = 1'b0;
    localparam logic        RST_FONT_W     = 1'b0;
    localparam logic        RST_CURSOR_ST  = 1'b0;
    localparam int          BLINK_FRAMES   = 32;
endpackage : glyph_pkg

// ---- hw/glyph_ram_if.sv ----
// glyph_ram_if: write and read port bundle of the user glyph memory.
// assumes both ends share ref_clk_i.
`timescale 1ns/1ps
interface glyph_ram_if #(parameter int AW = 6, parameter int DW = 8);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : glyph_ram_if

// ---- hw/glyph_ram.sv ----
// glyph_ram: small synchronous memory, registered read data.
// assumes a single clock; contents undefined until written.
`timescale 1ns/1ps
module glyph_ram #(
    parameter int DEPTH = 64
) (
    input  wire logic  ref_clk_i,
    input  wire logic  ce_i,
    glyph_ram_if.mem   port
);
    logic [7:0] mem_ff [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (ce_i && port.we) begin
            mem_ff[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
            port.rdata <= mem_ff[port.raddr];
        end
    end
endmodule : glyph_ram

// ---- hw/glyph_icon_pattern_lookup.sv ----
// glyph_icon_pattern_lookup: text code to dot row, icon RAM to segment lines.
// assumes writers and scan timing sit on ref_clk_i; frame_tick_i is one pulse per frame.
`timescale 1ns/1ps
module glyph_icon_pattern_lookup #(
    parameter int BLINK_FRAMES = glyph_pkg::BLINK_FRAMES
) (
    input  wire logic         ref_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         ce_i,
    input  wire logic         font_width_select_i,
    input  wire logic         pattern_blink_enable_i,
    input  wire logic         cursor_style_select_i,
    input  wire logic         frame_tick_i,
    input  wire logic         ug_we_i,
    input  wire logic [5:0]   ug_waddr_i,
    input  wire logic [7:0]   ug_wdata_i,
    input  wire logic         icon_we_i,
    input  wire logic [3:0]   icon_waddr_i,
    input  wire logic [7:0]   icon_wdata_i,
    input  wire logic         rom_we_i,
    input  wire logic [10:0]  rom_waddr_i,
    input  wire logic [4:0]   rom_wdata_i,
    input  wire logic [7:0]   text_code_i,
    input  wire logic [2:0]   row_i,
    input  wire logic         cursor_on_i,
    input  wire logic         common_row_first_i,
    input  wire logic         common_row_last_i,
    output logic [5:0]        dot_row_o,
    output logic              dot_row_valid_o,
    output logic [59:0]       segment_local_o,
    output logic [35:0]       segment_ext_o,
    output logic              segment_valid_o,
    output logic              font_width_o,
    output logic              blink_phase_on_o,
    output logic              cursor_style_o
);
    localparam int PH_W = $clog2(BLINK_FRAMES + 1);

    logic              font_w_ff;
    logic              blink_en_ff;
    logic              cursor_st_ff;
    logic [PH_W-1:0]   frame_cnt_ff;
    logic              phase_on_ff;
    logic              is_user_ff;
    logic              is_cursor_row_ff;
    logic              cursor_ff;
    logic              rom_hit_ff;
    logic              rom_in_area;
    logic [10:0]       rom_raddr;
    logic [glyph_pkg::ROM_PATTERNS*8-1:0] rom_set_ff;
    logic [7:0]        icon_ff [glyph_pkg::ICON_ENTRIES];
    logic [95:0]       nxt_seg;

    glyph_ram_if #(.AW(glyph_pkg::UG_ADDR_W), .DW(8)) ug_bus ();

    glyph_ram #(
        .DEPTH (64)
    ) u_user_glyph_ram (
        .ref_clk_i (ref_clk_i),
        .ce_i      (ce_i),
        .port      (ug_bus.mem)
    );

    glyph_ram_if #(.AW(11), .DW(8)) rom_bus ();

    glyph_ram #(
        .DEPTH (glyph_pkg::ROM_PATTERNS * 8)
    ) u_fixed_glyph_rom (
        .ref_clk_i (ref_clk_i),
        .ce_i      (ce_i),
        .port      (rom_bus.mem)
    );

    // blink gating shared by user glyph rows and icon entries
    function automatic logic [5:0] apply_blink(input logic [7:0] d, input logic fw, input logic en,
                                               input logic on);
        logic [5:0] keep;
        keep = d[5:0];
        if (!fw) begin
            keep[5] = 1'b0;
        end
        if (en && !on) begin
            if (d[glyph_pkg::BLINK_BIT_ALL]) begin
                keep = '0;
            end
            if (d[glyph_pkg::BLINK_BIT_EDGE]) begin
                if (fw) begin
                    keep[5] = 1'b0;
                end else begin
                    keep[4] = 1'b0;
                end
            end
        end
        return keep;
    endfunction : apply_blink

    assign ug_bus.we    = ug_we_i;
    assign ug_bus.waddr = ug_waddr_i;
    assign ug_bus.wdata = ug_wdata_i;
    assign ug_bus.raddr = {text_code_i[2:0], row_i};

    // fixed glyph ROM, loadable; bits 7..5 of a word always stored as zero
    assign rom_in_area   = rom_waddr_i < 11'(glyph_pkg::ROM_PATTERNS * 8);
    assign rom_raddr     = 11'({text_code_i - 8'h10, row_i});
    assign rom_bus.we    = rom_we_i && rom_in_area;
    assign rom_bus.waddr = rom_waddr_i;
    assign rom_bus.wdata = {3'h0, rom_wdata_i};
    assign rom_bus.raddr = rom_raddr;

    // control copies; reset gives no blink, five dots, normal cursor
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            blink_en_ff  <= glyph_pkg::RST_BLINK_EN;
            font_w_ff    <= glyph_pkg::RST_FONT_W;
            cursor_st_ff <= glyph_pkg::RST_CURSOR_ST;
        end else if (ce_i) begin
            blink_en_ff  <= pattern_blink_enable_i;
            font_w_ff    <= font_width_select_i;
            cursor_st_ff <= cursor_style_select_i;
        end
    end

    // free-running frame counter; half period on, half off
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_cnt_ff <= '0;
            phase_on_ff  <= 1'b1;
        end else if (ce_i && frame_tick_i) begin
            if (frame_cnt_ff == PH_W'(BLINK_FRAMES / 2 - 1)) begin
                frame_cnt_ff <= '0;
                phase_on_ff  <= ~phase_on_ff;
            end else begin
                frame_cnt_ff <= frame_cnt_ff + 1'b1;
            end
        end
    end

    // one mark per ROM row; an unloaded row reads as an erased part, all dots lit
    // limitation: loads are forgotten on reset, so loaders must run after it
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rom_set_ff <= '0;
        end else if (ce_i && rom_bus.we) begin
            rom_set_ff[rom_waddr_i] <= 1'b1;
        end
    end

    // user codes map past the ROM area; the and keeps that read from mattering
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rom_hit_ff <= 1'b0;
        end else if (ce_i) begin
            rom_hit_ff <= (text_code_i[7:4] != glyph_pkg::USER_CODE_HI) && rom_set_ff[rom_raddr];
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            is_user_ff       <= 1'b0;
            is_cursor_row_ff <= 1'b0;
            cursor_ff        <= 1'b0;
        end else if (ce_i) begin
            is_user_ff       <= (text_code_i[7:4] == glyph_pkg::USER_CODE_HI);
            is_cursor_row_ff <= (row_i == glyph_pkg::CURSOR_ROW);
            cursor_ff        <= cursor_on_i && !cursor_style_select_i;
        end
    end

    // output row, one cycle after the memories answer
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dot_row_o       <= '0;
            dot_row_valid_o <= 1'b0;
        end else if (ce_i) begin
            dot_row_valid_o <= 1'b1;
            if (is_user_ff) begin
                dot_row_o <= apply_blink(ug_bus.rdata, font_w_ff, blink_en_ff, phase_on_ff)
                             | {6{is_cursor_row_ff && cursor_ff}};
            end else if (rom_hit_ff) begin
                dot_row_o <= {1'b0, rom_bus.rdata[4:0]} | {6{is_cursor_row_ff && cursor_ff}};
            end else begin
                dot_row_o <= glyph_pkg::ROM_BLANK_ROW | {6{is_cursor_row_ff && cursor_ff}};
            end
        end
    end

    // icon segment RAM
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < glyph_pkg::ICON_ENTRIES; i++) begin
                icon_ff[i] <= '0;
            end
        end else if (ce_i && icon_we_i) begin
            icon_ff[icon_waddr_i] <= icon_wdata_i;
        end
    end

    // map entries to a 96-position line; index 0 is the leftmost output
    always_comb begin
        logic [5:0] bits;
        bits    = '0;
        nxt_seg = '0;
        for (int n = 0; n < glyph_pkg::ICON_ENTRIES; n++) begin
            bits = apply_blink(icon_ff[n], font_w_ff, blink_en_ff, phase_on_ff);
            for (int k = 0; k < 6; k++) begin
                if (font_w_ff) begin
                    nxt_seg[n * 6 + k] = bits[5 - k];
                end else if (k < 5) begin
                    nxt_seg[n * 5 + k] = bits[4 - k];
                end
            end
        end
    end

    // positions past 80 (5-wide) stay zero, so the line wraps to the first output
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            segment_local_o <= '0;
            segment_ext_o   <= '0;
            segment_valid_o <= 1'b0;
        end else if (ce_i) begin
            if (common_row_first_i || common_row_last_i) begin
                segment_local_o <= nxt_seg[59:0];
                segment_ext_o   <= nxt_seg[95:60];
                segment_valid_o <= 1'b1;
            end else begin
                segment_local_o <= '0;
                segment_ext_o   <= '0;
                segment_valid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            font_width_o     <= glyph_pkg::RST_FONT_W;
            blink_phase_on_o <= 1'b1;
            cursor_style_o   <= glyph_pkg::RST_CURSOR_ST;
        end else if (ce_i) begin
            font_width_o     <= font_w_ff;
            blink_phase_on_o <= phase_on_ff;
            cursor_style_o   <= cursor_st_ff;
        end
    end
endmodule : glyph_icon_pattern_lookup

// ---- tb/glyph_lookup_asserts.sv ----
// glyph_lookup_asserts: timing checks on the lookup block ports.
// assumes it is bound into glyph_icon_pattern_lookup; one clock domain.
`timescale 1ns/1ps
module glyph_lookup_asserts (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        ce_i,
    input wire logic        font_width_select_i,
    input wire logic        cursor_style_select_i,
    input wire logic        frame_tick_i,
    input wire logic [2:0]  row_i,
    input wire logic        cursor_on_i,
    input wire logic        common_row_first_i,
    input wire logic        common_row_last_i,
    input wire logic [5:0]  dot_row_o,
    input wire logic        dot_row_valid_o,
    input wire logic [35:0] segment_ext_o,
    input wire logic        segment_valid_o,
    input wire logic        font_width_o,
    input wire logic        blink_phase_on_o,
    input wire logic        cursor_style_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_seg_on; ce_i && (common_row_first_i || common_row_last_i) |=> segment_valid_o; endproperty
    a_seg_on: assert property (p_seg_on) else $error("segment valid missing");
    property p_seg_off; ce_i && !common_row_first_i && !common_row_last_i |=> !segment_valid_o; endproperty
    a_seg_off: assert property (p_seg_off) else $error("segment valid off row");
    // width copy and the segment register both load from font_w_ff on the same edge
    property p_wrap5; (!font_width_o)[*3] |-> (($past(segment_ext_o) >> 20) == 36'h0); endproperty
    a_wrap5: assert property (p_wrap5) else $error("segments past 80 in five-dot width");
    property p_fw; ce_i[*2] |=> font_width_o == $past(font_width_select_i, 2); endproperty
    a_fw: assert property (p_fw) else $error("font width copy wrong");
    property p_cst; ce_i[*2] |=> cursor_style_o == $past(cursor_style_select_i, 2); endproperty
    a_cst: assert property (p_cst) else $error("cursor style copy wrong");
    property p_tick; $changed(blink_phase_on_o) |-> $past(frame_tick_i) || $past(frame_tick_i, 2)
        || $past(frame_tick_i, 3); endproperty
    a_tick: assert property (p_tick) else $error("blink phase moved without frame tick");
    property p_cursor; (!cursor_style_select_i)[*2] ##1 (ce_i && cursor_on_i && row_i == 3'h7
        && !cursor_style_select_i)[*3] |=> dot_row_o[4:0] == 5'h1f; endproperty
    a_cursor: assert property (p_cursor) else $error("cursor row not lit");
    property p_dvalid; ce_i[*3] |=> dot_row_valid_o; endproperty
    a_dvalid: assert property (p_dvalid) else $error("dot row valid low");
endmodule : glyph_lookup_asserts
bind glyph_icon_pattern_lookup glyph_lookup_asserts chk_u (.*);

// ---- tb/seg_panel_model.sv ----
// seg_panel_model: column driver plus extension driver, holds 96 segment lines.
// assumes segment data is launched on ref_clk_i by the lookup block.
`timescale 1ns/1ps
module seg_panel_model (
    input  wire logic        ref_clk_i,
    input  wire logic [59:0] local_i,
    input  wire logic [35:0] ext_i,
    input  wire logic        valid_i,
    output logic      [95:0] image_o
);
    // no reset: a cleared image must not hide a stale icon memory
    always_ff @(posedge ref_clk_i) begin
        if (valid_i) begin
            image_o <= {ext_i, local_i};
        end
    end
endmodule : seg_panel_model

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the glyph and icon lookup block.
// assumes one 250 MHz clock; the panel model stands on the segment lines.
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [7:0] c; logic [2:0] r; logic fw; logic [5:0] e;} row_case_t;
    logic ref_clk_i, reset_n_i, ce_i, font_width_select_i, pattern_blink_enable_i, cursor_style_select_i;
    logic frame_tick_i, ug_we_i, icon_we_i, rom_we_i, cursor_on_i, common_row_first_i, common_row_last_i;
    logic dot_row_valid_o, segment_valid_o, font_width_o, blink_phase_on_o, cursor_style_o;
    logic [5:0]  ug_waddr_i, dot_row_o;
    logic [7:0]  ug_wdata_i, icon_wdata_i, text_code_i, ic [16];
    logic [3:0]  icon_waddr_i;
    logic [10:0] rom_waddr_i;
    logic [4:0]  rom_wdata_i;
    logic [2:0]  row_i;
    logic [59:0] segment_local_o;
    logic [35:0] segment_ext_o;
    logic [95:0] image;
    int          n_errors = 0;
    int          compares = 0;
    row_case_t   tv [8] = '{'{8'h02, 3'h3, 1'b0, 6'h15}, '{8'h0a, 3'h3, 1'b0, 6'h15}, '{8'h05, 3'h1, 1'b1, 6'h2a},
        '{8'h05, 3'h1, 1'b0, 6'h0a}, '{8'h41, 3'h2, 1'b0, 6'h0e}, '{8'h42, 3'h0, 1'b0, 6'h1f},
        '{8'h43, 3'h4, 1'b0, 6'h00}, '{8'hff, 3'h7, 1'b0, 6'h1f}};
    // kind 0 user glyph, 1 icon, 2 fixed rom
    logic [20:0] wt [12] = '{{2'h0, 11'h013, 8'h15}, {2'h0, 11'h029, 8'h2a}, {2'h0, 11'h017, 8'h00},
        {2'h0, 11'h018, 8'h91}, {2'h2, 11'h18a, 8'h0e}, {2'h2, 11'h19c, 8'h00}, {2'h2, 11'h7ff, 8'h00},
        {2'h1, 11'h000, 8'h23}, {2'h1, 11'h001, 8'h90}, {2'h1, 11'h002, 8'h51}, {2'h1, 11'h00c, 8'h10},
        {2'h1, 11'h00f, 8'h1f}};
    glyph_icon_pattern_lookup #(.BLINK_FRAMES(2)) dut_u (.*);
    seg_panel_model panel_u (.ref_clk_i(ref_clk_i), .local_i(segment_local_o), .ext_i(segment_ext_o),
        .valid_i(segment_valid_o), .image_o(image));
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : step
    task automatic chk_img(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_img
    task automatic chk_row(input logic [5:0] got, input logic [5:0] exp);
        chk_img({90'h0, got}, {90'h0, exp});
    endtask : chk_row
    task automatic wr(input logic [1:0] k, input logic [10:0] a, input logic [7:0] d);
        {ug_waddr_i, icon_waddr_i, rom_waddr_i} = {a[5:0], a[3:0], a};
        {ug_wdata_i, icon_wdata_i, rom_wdata_i} = {d, d, d[4:0]};
        {ug_we_i, icon_we_i, rom_we_i} = {k == 2'h0, k == 2'h1, k == 2'h2};
        step(1);
        {ug_we_i, icon_we_i, rom_we_i} = 3'h0;
        if (k == 2'h1) ic[a[3:0]] = d;
        step(1);
    endtask : wr
    function automatic logic [95:0] img(input logic fw, input logic on);
        int w;
        img = 96'h0;
        w = fw ? 6 : 5;
        for (int n = 0; n < 16; n++) begin
            for (int k = 0; k < w; k++) begin
                if (ic[n][k] && !(pattern_blink_enable_i && !on && (ic[n][7] || (ic[n][6] && k == w - 1)))) begin
                    img[w * n + w - 1 - k] = 1'b1;
                end
            end
        end
    endfunction : img
    task automatic summarize();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // whole run needs well under 1000 cycles
    initial begin
        #40000;
        n_errors++;
        summarize();
    end
    initial begin
        {reset_n_i, font_width_select_i, pattern_blink_enable_i, cursor_style_select_i, frame_tick_i} = 5'h0;
        {ug_we_i, icon_we_i, rom_we_i, cursor_on_i, common_row_first_i, common_row_last_i} = 6'h0;
        {ug_waddr_i, ug_wdata_i, icon_waddr_i, icon_wdata_i, rom_waddr_i, rom_wdata_i} = '0;
        {text_code_i, row_i} = 11'h0;
        ce_i = 1'b1;
        foreach (ic[i]) ic[i] = 8'h00;
        step(16);
        reset_n_i = 1'b1;
        foreach (wt[i]) wr(wt[i][20:19], wt[i][18:8], wt[i][7:0]);
        foreach (tv[i]) begin
            {text_code_i, row_i, font_width_select_i} = {tv[i].c, tv[i].r, tv[i].fw};
            step(5);
            chk_row(dot_row_o & {tv[i].fw, 5'h1f}, tv[i].e);
        end
        $display("lookup table done");
        {text_code_i, row_i, cursor_on_i, font_width_select_i} = {8'h02, 3'h7, 1'b1, 1'b0};
        step(5);
        chk_row(dot_row_o & 6'h1f, 6'h1f);
        cursor_style_select_i = 1'b1;
        step(5);
        chk_row(dot_row_o & 6'h1f, 6'h00);
        {cursor_style_select_i, cursor_on_i} = 2'h0;
        $display("cursor done");
        for (int f = 0; f < 2; f++) begin
            {font_width_select_i, common_row_first_i, common_row_last_i} = {f[0], !f[0], f[0]};
            step(4);
            chk_img(image, img(f[0], 1'b1));
        end
        {font_width_select_i, common_row_last_i} = 2'h0;
        step(2);
        chk_row({5'h0, segment_valid_o}, 6'h00);
        chk_img({segment_ext_o, segment_local_o}, 96'h0);
        $display("icon done");
        {common_row_first_i, pattern_blink_enable_i, text_code_i, row_i} = {2'h3, 8'h03, 3'h0};
        step(4);
        for (int p = 0; p < 3; p++) begin
            chk_row({5'h0, blink_phase_on_o}, {5'h0, p != 1});
            chk_img(image, img(1'b0, p != 1));
            chk_row(dot_row_o & 6'h1f, (p == 1) ? 6'h00 : 6'h11);
            frame_tick_i = 1'b1;
            step(1);
            frame_tick_i = 1'b0;
            step(5);
        end
        $display("blink done");
        // enable low must freeze phase and row although ticks and a new code arrive
        {ce_i, frame_tick_i, text_code_i, row_i} = {2'h1, 8'h02, 3'h3};
        step(3);
        chk_row({dot_row_o[4:0], blink_phase_on_o}, 6'h00);
        {ce_i, frame_tick_i} = 2'h2;
        pattern_blink_enable_i = 1'b0;
        $display("enable freeze done");
        {font_width_select_i, cursor_style_select_i} = 2'h3;
        step(4);
        {reset_n_i, font_width_select_i, cursor_style_select_i} = 3'h0;
        #1;
        chk_row({2'h0, dot_row_valid_o, font_width_o, cursor_style_o, blink_phase_on_o}, 6'h01);
        foreach (ic[i]) ic[i] = 8'h00;
        step(16);
        reset_n_i = 1'b1;
        step(4);
        chk_img(image, img(1'b0, 1'b1));
        $display("reset done");
        summarize();
    end
endmodule : tb_top
